/* File: cmd_params.svh */
// Field values, limits, source count and codes for the command block
`ifndef CMD_PARAMS_SVH
`define CMD_PARAMS_SVH
`define OP_ROTATE_CW 8'h01
`define OP_ROTATE_CCW 8'h02
`define OP_GLOBAL_PARAM_WRITE 8'h09
`define OP_IRQ_ENABLE 8'h19
`define OP_IRQ_DISABLE 8'h1a
`define OP_IRQ_VECTOR_SET 8'h25
`define OP_IRQ_RETURN 8'h26
`define IRQ_BANK 8'h03
`define IRQ_NUM_TIMER0 8'h00
`define IRQ_NUM_TIMER1 8'h01
`define IRQ_NUM_TIMER2 8'h02
`define IRQ_NUM_POS_REACHED 8'h03
`define IRQ_NUM_STALL 8'h0f
`define IRQ_NUM_DEVIATION 8'h15
`define IRQ_NUM_STOP_LEFT 8'h1b
`define IRQ_NUM_STOP_RIGHT 8'h1c
`define IRQ_NUM_INPUT0 8'h27
`define IRQ_NUM_ALL 8'hff
`define STATUS_OK 8'h64
`define STATUS_BAD_CHECKSUM 8'h01
`define STATUS_BAD_OPCODE 8'h02
`define STATUS_BAD_VALUE 8'h04
`define VEL_LIMIT 32'sd2047
`define AXIS_PARAM_TARGET_VEL 8'h02
`define NUM_SOURCES 12
`endif

/* File: cmd_pkg.sv */
// Types shared by the command interpreter files
package cmd_pkg;
    // One decoded binary command frame
    typedef struct packed {
        logic [7:0] address;
        logic [7:0] opcode;
        logic [7:0] kind;
        logic [7:0] bank;
        logic [31:0] value;
        logic [7:0] checksum;
    } frame_s;
    // Reply sent back in direct mode
    typedef struct packed {
        logic [7:0] status;
        logic [7:0] opcode;
        logic [31:0] value;
    } reply_s;
    // Saved program context
    typedef struct packed {
        logic [31:0] accu;
        logic [31:0] xreg;
        logic [7:0] flags;
        logic [15:0] pc;
    } context_s;
    // Interpreter states
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_VEL_MODE,
        ST_VEL_LOAD,
        ST_REPLY
    } exec_state_e;
endpackage

/* File: irq_source_map.sv */
// Maps interrupt numbers onto source slots and flags the global enable number
`timescale 1ns/1ps
`default_nettype none
`include "cmd_params.svh"
module irq_source_map #(
    parameter int NUM_SOURCES = `NUM_SOURCES
) (
    input wire logic [7:0] irq_number,
    output logic [3:0] slot,
    output logic slot_valid,
    output logic is_global
);
    // Source numbering: timers, position, stall, deviation, stops, inputs
    assign slot_valid = (irq_number <= `IRQ_NUM_POS_REACHED) ||
                        (irq_number == `IRQ_NUM_STALL) ||
                        (irq_number == `IRQ_NUM_DEVIATION) ||
                        (irq_number == `IRQ_NUM_STOP_LEFT) ||
                        (irq_number == `IRQ_NUM_STOP_RIGHT) ||
                        ((irq_number >= `IRQ_NUM_INPUT0) &&
                         (irq_number <= `IRQ_NUM_INPUT0 + 8'h03)); // [R3] [R4] [R5]
    // Global enable number 255
    assign is_global = (irq_number == `IRQ_NUM_ALL); // [R6]
    // Slot index: 0-3 direct, then 4..7, inputs 8..11
    assign slot = (irq_number <= `IRQ_NUM_POS_REACHED) ? irq_number[3:0] :
                  (irq_number == `IRQ_NUM_STALL) ? 4'h4 :
                  (irq_number == `IRQ_NUM_DEVIATION) ? 4'h5 :
                  (irq_number == `IRQ_NUM_STOP_LEFT) ? 4'h6 :
                  (irq_number == `IRQ_NUM_STOP_RIGHT) ? 4'h7 :
                  slot_valid ? 4'(irq_number - `IRQ_NUM_INPUT0 + 8'h08) :
                  4'h0; // [R3]
endmodule // irq_source_map
`default_nettype wire

/* File: frame_check.sv */
// Checks a command frame's checksum and rotate fields
`timescale 1ns/1ps
`default_nettype none
`include "cmd_params.svh"
module frame_check (
    input wire cmd_pkg::frame_s frame,
    output logic sum_ok,
    output logic rotate_fields_ok
);
    import cmd_pkg::*;
    logic [7:0] sum; // Low byte of the eight-byte sum
    // Sum of all bytes ahead of the checksum
    assign sum = frame.address + frame.opcode + frame.kind + frame.bank +
                 frame.value[31:24] + frame.value[23:16] +
                 frame.value[15:8] + frame.value[7:0]; // [R20] [R23]
    assign sum_ok = (sum == frame.checksum); // [R23]
    // Rotate needs zero type and motor, velocity within limit
    assign rotate_fields_ok = (frame.kind == 8'h00) &&
                              (frame.bank == 8'h00) &&
                              ($signed(frame.value) <= `VEL_LIMIT) &&
                              ($signed(frame.value) >= -`VEL_LIMIT); // [R18] [R21]
endmodule // frame_check
`default_nettype wire

/* File: cmd_interp.sv */
// Command interpreter: interrupt commands and rotate commands
// How it works
// (R1) Codes 25 and 26 enable, disable sources
// (R2) Code 37 sets vector, 38 returns
// (R3) Own slot per source; timers 0-2, position 3
// (R4) Stall 15, deviation 21, stops 27, 28
// (R5) Input changes 39 to 42, own enables
// (R6) Number 255 is the global enable
// (R7) Dispatch only if enabled and vector valid
// (R8) Save accumulator, X register, flags first
// (R9) No nesting; pending waits for return
// (R10) Return restores context and resumes program
// (R11) Bank 3 global writes configure sources
// (R12) Program sets vector, config, enable, global
// (R13) Every handler ends with the return command
// (R14) Program never falls into handler code
// (R15) Rotate right: increasing position, given speed
// (R16) Rotate left: decreasing position, given speed
// (R17) Select velocity mode, then load target velocity
// (R18) Velocity signed, within plus minus 2047
// (R19) Direct-mode rotate replies status 100
// (R20) Frame: address, opcode, type, bank, value, sum
// (R21) Opcode 1 right, 2 left; zero fields
// (R22) Direct-mode reads leave accumulator alone
// (R23) Checksum is low byte of sum
`timescale 1ns/1ps
`default_nettype none
`include "cmd_params.svh"
module cmd_interp #(
    parameter int NUM_SOURCES = `NUM_SOURCES
) (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic frame_valid,
    input wire cmd_pkg::frame_s frame,
    input wire logic direct_mode,
    input wire logic [NUM_SOURCES-1:0] irq_event,
    input wire cmd_pkg::context_s prog_context,
    input wire logic read_result_valid,
    input wire logic [31:0] read_result,
    output logic reply_valid,
    output cmd_pkg::reply_s reply,
    output logic irq_call,
    output logic [15:0] irq_call_addr,
    output logic irq_resume,
    output cmd_pkg::context_s restore_context,
    output logic [31:0] accu_out,
    output logic in_handler,
    output logic velocity_mode,
    output logic motor_dir_ccw,
    output logic axis_param_write,
    output logic [7:0] axis_param_num,
    output logic [31:0] axis_param_value,
    output logic irq_cfg_write,
    output logic [7:0] irq_cfg_number,
    output logic [31:0] irq_cfg_value
);
    import cmd_pkg::*;

    exec_state_e state_reg, state_next; // Rotate sequencing state
    logic [NUM_SOURCES-1:0] enable_reg; // Per-source enables
    logic [NUM_SOURCES-1:0] vec_valid_reg; // Per-source vector defined
    logic [NUM_SOURCES-1:0] pending_reg; // Latched source events
    logic [15:0] vector_reg [NUM_SOURCES]; // Handler addresses
    logic global_en_reg; // Global interrupt enable
    logic in_handler_reg; // Handler running
    context_s saved_reg; // Saved main-program context
    logic [31:0] vel_reg; // Velocity held between steps
    logic ccw_reg; // Direction held between steps
    logic [7:0] op_reg; // Opcode for reply
    logic [3:0] slot; // Decoded slot of command number
    logic slot_valid; // Command number maps to a source
    logic is_global; // Command number is 255
    logic sum_ok; // Checksum matches
    logic rot_ok; // Rotate fields legal
    logic take; // Frame accepted this cycle
    logic [NUM_SOURCES-1:0] ready; // Sources able to dispatch
    logic [3:0] win; // Lowest ready source
    logic any_ready; // Some source ready
    logic dispatch; // Call a handler now
    logic is_rot; // Opcode is a rotate
    logic [7:0] status_next; // Reply status for non-rotate frames

    // Maps the interrupt number in the type field to a slot
    irq_source_map #(.NUM_SOURCES(NUM_SOURCES)) u_map (
        .irq_number(frame.kind),
        .slot(slot),
        .slot_valid(slot_valid),
        .is_global(is_global)
    );

    // Checks checksum and rotate fields
    frame_check u_check (
        .frame(frame),
        .sum_ok(sum_ok),
        .rotate_fields_ok(rot_ok)
    );

    // Frames are taken only while no rotate is in progress
    assign take = frame_valid && (state_reg == ST_IDLE) && sum_ok; // [R23]
    // Rotate opcodes start the velocity sequence
    assign is_rot = (frame.opcode == `OP_ROTATE_CW) ||
                    (frame.opcode == `OP_ROTATE_CCW); // [R21]
    // A source may fire once pending, enabled and vectored
    assign ready = pending_reg & enable_reg & vec_valid_reg; // [R7]
    assign any_ready = |ready;
    // No dispatch while a handler runs or in the command cycle
    assign dispatch = any_ready && global_en_reg && !in_handler_reg &&
                      !take; // [R6] [R9]

    // Lowest numbered ready slot wins
    always_comb begin
        win = 4'h0;
        for (int i = NUM_SOURCES - 1; i >= 0; i--) begin
            if (ready[i]) begin
                win = 4'(i);
            end
        end
    end

    // Status for frames that are not rotates
    assign status_next =
        (frame.opcode == `OP_IRQ_ENABLE) ||
        (frame.opcode == `OP_IRQ_DISABLE) ||
        (frame.opcode == `OP_IRQ_VECTOR_SET) ||
        (frame.opcode == `OP_IRQ_RETURN) ||
        (frame.opcode == `OP_GLOBAL_PARAM_WRITE) ? `STATUS_OK :
        `STATUS_BAD_OPCODE;

    // Rotate sequence: velocity mode, then target velocity
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE: begin
                if (take && is_rot && rot_ok) begin
                    state_next = ST_VEL_MODE;
                end
            end
            ST_VEL_MODE: begin
                state_next = ST_VEL_LOAD; // [R17]
            end
            ST_VEL_LOAD: begin
                state_next = ST_REPLY;
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    // State register
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            state_reg <= ST_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // Per-source enable, vector and pending bits
    genvar g;
    generate
        for (g = 0; g < NUM_SOURCES; g++) begin : g_src
            logic hit; // Command addresses this slot
            assign hit = take && slot_valid && (slot == 4'(g));
            always_ff @(posedge ref_clk) begin
                if (reset) begin
                    enable_reg[g] <= 1'b0;
                    vec_valid_reg[g] <= 1'b0;
                    vector_reg[g] <= 16'h0000;
                    pending_reg[g] <= 1'b0;
                end else begin
                    if (hit && frame.opcode == `OP_IRQ_ENABLE) begin
                        enable_reg[g] <= 1'b1; // [R1] [R5]
                    end else if (hit && frame.opcode == `OP_IRQ_DISABLE) begin
                        enable_reg[g] <= 1'b0; // [R1]
                    end
                    if (hit && frame.opcode == `OP_IRQ_VECTOR_SET) begin
                        vector_reg[g] <= frame.value[15:0]; // [R2] [R3]
                        vec_valid_reg[g] <= 1'b1;
                    end
                    // New event wins over the dispatch clear
                    if (irq_event[g]) begin
                        pending_reg[g] <= 1'b1;
                    end else if (dispatch && win == 4'(g)) begin
                        pending_reg[g] <= 1'b0;
                    end
                end
            end
        end
    endgenerate

    // Global enable, handler flag and context save
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            global_en_reg <= 1'b0;
            in_handler_reg <= 1'b0;
            saved_reg <= '0;
            irq_call <= 1'b0;
            irq_call_addr <= 16'h0000;
            irq_resume <= 1'b0;
            restore_context <= '0;
        end else begin
            irq_call <= dispatch; // [R7]
            irq_resume <= 1'b0;
            if (take && is_global) begin
                if (frame.opcode == `OP_IRQ_ENABLE) begin
                    global_en_reg <= 1'b1; // [R6]
                end else if (frame.opcode == `OP_IRQ_DISABLE) begin
                    global_en_reg <= 1'b0; // [R6]
                end
            end
            if (dispatch) begin
                saved_reg <= prog_context; // [R8]
                irq_call_addr <= vector_reg[win]; // [R7]
                in_handler_reg <= 1'b1; // [R9]
            end else if (take && in_handler_reg &&
                         frame.opcode == `OP_IRQ_RETURN) begin
                restore_context <= saved_reg; // [R10]
                irq_resume <= 1'b1; // [R10]
                in_handler_reg <= 1'b0; // [R9]
            end
        end
    end

    // Accumulator takes read results only from stored programs
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            accu_out <= 32'h0000_0000;
        end else if (read_result_valid && !direct_mode) begin
            accu_out <= read_result; // [R22]
        end
    end

    // Axis outputs and source configuration writes
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            velocity_mode <= 1'b0;
            motor_dir_ccw <= 1'b0;
            axis_param_write <= 1'b0;
            axis_param_num <= 8'h00;
            axis_param_value <= 32'h0000_0000;
            vel_reg <= 32'h0000_0000;
            ccw_reg <= 1'b0;
            op_reg <= 8'h00;
            irq_cfg_write <= 1'b0;
            irq_cfg_number <= 8'h00;
            irq_cfg_value <= 32'h0000_0000;
        end else begin
            axis_param_write <= 1'b0;
            irq_cfg_write <= 1'b0;
            if (state_reg == ST_IDLE && state_next == ST_VEL_MODE) begin
                vel_reg <= frame.value;
                ccw_reg <= (frame.opcode == `OP_ROTATE_CCW); // [R15] [R16]
                op_reg <= frame.opcode;
            end
            if (state_reg == ST_VEL_MODE) begin
                velocity_mode <= 1'b1; // [R17]
                motor_dir_ccw <= ccw_reg; // [R15] [R16]
            end
            if (state_reg == ST_VEL_LOAD) begin
                axis_param_write <= 1'b1; // [R17]
                axis_param_num <= `AXIS_PARAM_TARGET_VEL;
                axis_param_value <= vel_reg;
            end
            if (take && frame.opcode == `OP_GLOBAL_PARAM_WRITE &&
                frame.bank == `IRQ_BANK) begin
                irq_cfg_write <= 1'b1; // [R11]
                irq_cfg_number <= frame.kind;
                irq_cfg_value <= frame.value;
            end
        end
    end

    // Reply in direct mode
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            reply_valid <= 1'b0;
            reply <= '0;
        end else begin
            reply_valid <= 1'b0;
            if (state_reg == ST_REPLY && direct_mode) begin
                reply_valid <= 1'b1;
                reply.status <= `STATUS_OK; // [R19]
                reply.opcode <= op_reg;
                reply.value <= 32'h0000_0000;
            end else if (frame_valid && state_reg == ST_IDLE && direct_mode &&
                         !(sum_ok && is_rot && rot_ok)) begin
                reply_valid <= 1'b1;
                reply.status <= !sum_ok ? `STATUS_BAD_CHECKSUM :
                                is_rot ? `STATUS_BAD_VALUE : status_next;
                reply.opcode <= frame.opcode;
                reply.value <= 32'h0000_0000;
            end
        end
    end

    // Handler flag straight from its register
    assign in_handler = in_handler_reg;
endmodule // cmd_interp
`default_nettype wire

/* File: cmd_interp_assertions.sv */
// Checker for the command interpreter ports
`timescale 1ns/1ps
`default_nettype none
module cmd_interp_assertions
    import cmd_pkg::*;
(
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic frame_valid,
    input wire cmd_pkg::frame_s frame,
    input wire logic direct_mode,
    input wire cmd_pkg::context_s prog_context,
    input wire logic read_result_valid,
    input wire logic [31:0] read_result,
    input wire logic reply_valid,
    input wire cmd_pkg::reply_s reply,
    input wire logic irq_call,
    input wire logic irq_resume,
    input wire cmd_pkg::context_s restore_context,
    input wire logic [31:0] accu_out,
    input wire logic in_handler,
    input wire logic velocity_mode,
    input wire logic axis_param_write,
    input wire logic [7:0] axis_param_num,
    input wire logic irq_cfg_write,
    input wire logic [7:0] irq_cfg_number,
    input wire logic [31:0] irq_cfg_value
);
    context_s prev_ctx; // Context one cycle back
    context_s saved_ctx; // Context taken at dispatch
    frame_s prev_frame; // Frame one cycle back
    logic prev_fv; // Strobe one cycle back
    // Mirror what the design sampled on the previous edge
    always_ff @(posedge ref_clk) begin
        prev_ctx <= prog_context;
        prev_frame <= frame;
        prev_fv <= frame_valid;
        if (irq_call) begin
            saved_ctx <= prev_ctx;
        end
    end
    default clocking @(posedge ref_clk); endclocking
    default disable iff (reset);
    a_param_num_two: assert property (
        axis_param_write |-> axis_param_num == 8'h02)
        else $error("Speed written to wrong parameter");
    a_mode_before_speed: assert property (
        axis_param_write |-> $past(velocity_mode))
        else $error("Speed loaded before velocity mode");
    a_rotate_reply_ok: assert property (
        axis_param_write && direct_mode |=>
        reply_valid && reply.status == 8'h64)
        else $error("Rotate reply missing or not OK");
    a_call_not_nested: assert property (
        irq_call |-> in_handler && !$past(in_handler))
        else $error("Handler called while busy");
    a_resume_restores: assert property (
        irq_resume |-> restore_context == saved_ctx && !in_handler)
        else $error("Restored context differs");
    a_resume_in_handler: assert property (
        irq_resume |-> $past(in_handler))
        else $error("Resume outside a handler");
    a_direct_read_keeps: assert property (
        read_result_valid && direct_mode |=> $stable(accu_out))
        else $error("Direct read changed accumulator");
    a_prog_read_loads: assert property (
        read_result_valid && !direct_mode |=>
        accu_out == $past(read_result))
        else $error("Program read not in accumulator");
    a_cfg_from_bank: assert property (
        irq_cfg_write |-> prev_fv && prev_frame.bank == 8'h03 &&
        irq_cfg_number == prev_frame.kind &&
        irq_cfg_value == prev_frame.value)
        else $error("Source setting not from bank 3 write");
endmodule // cmd_interp_assertions
bind cmd_interp cmd_interp_assertions i_chk (.*);
`default_nettype wire

/* File: cmd_host.sv */
// Host model issuing checksummed command frames
`timescale 1ns/1ps
`default_nettype none
module cmd_host (
    input wire logic ref_clk,
    output cmd_pkg::frame_s frame,
    output logic frame_valid
);
    import cmd_pkg::*;
    // Idle with no frame offered
    initial begin
        frame_valid = 1'b0;
        frame = '0;
    end
    // Offer one frame for one cycle; bad spoils its checksum
    task automatic send(input logic [7:0] op, k, b,
        input logic [31:0] x, input logic bad);
        frame_s f;
        f = {8'h01, op, k, b, x, 8'h00};
        f.checksum = f.address + op + k + b + x[31:24] + x[23:16]
            + x[15:8] + x[7:0] + {7'h00, bad};
        @(posedge ref_clk);
        frame <= f;
        frame_valid <= 1'b1;
        @(posedge ref_clk);
        frame <= ~f; // Released lines stop showing the frame
        frame_valid <= 1'b0;
    endtask
endmodule // cmd_host
`default_nettype wire

/* File: tb.sv */
// Self-checking bench for the command interpreter
`timescale 1ns/1ps
`default_nettype none
module tb;
    import cmd_pkg::*;
    logic ref_clk, reset, frame_valid, direct_mode, read_result_valid;
    logic reply_valid, irq_call, irq_resume, in_handler, velocity_mode;
    logic motor_dir_ccw, axis_param_write, irq_cfg_write;
    logic [11:0] irq_event; // One line per source slot
    logic [15:0] irq_call_addr, call_addr;
    logic [31:0] read_result, accu_out, axis_param_value, irq_cfg_value, v;
    logic [7:0] axis_param_num, irq_cfg_number, op;
    frame_s frame;
    reply_s reply;
    context_s prog_context, restore_context;
    int n_errors, checks, calls, resumes, n, c;
    int seed = 6758;
    // Interrupt number of each slot
    logic [7:0] nums [12] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h0f, 8'h15,
        8'h1b, 8'h1c, 8'h27, 8'h28, 8'h29, 8'h2a};
    cmd_interp i_dut (.*);
    cmd_host i_host (.*);
    // Free-running clock
    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end
    // Count dispatch and resume pulses while they stand
    always @(posedge ref_clk) begin
        if (irq_call === 1'b1) begin
            calls++;
            call_addr = irq_call_addr;
        end
        if (irq_resume === 1'b1) resumes++;
    end
    // Compare and report
    task automatic chk(input string s, input logic [95:0] e, g);
        checks++;
        if (g !== e) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", s, e, g);
        end
    endtask
    // Status a frame should earn, worked out from the rules
    function automatic logic [7:0] want(input logic [7:0] o, k, b,
        input logic [31:0] x, input logic bad);
        logic rot;
        rot = (o == 8'h01) || (o == 8'h02);
        if (bad) return 8'h01;
        if (rot && (k != 8'h00 || b != 8'h00 || $signed(x) > 2047 ||
            $signed(x) < -2047)) return 8'h04;
        if (rot || o == 8'h09 || o == 8'h19 || o == 8'h1a ||
            o == 8'h25 || o == 8'h26) return 8'h64;
        return 8'h02;
    endfunction
    task automatic idle(input int k);
        repeat (k) @(posedge ref_clk);
        #1;
    endtask
    // Send a frame; n is the reply distance, 99 if none
    task automatic cmd(input logic [7:0] o, k, b, input logic [31:0] x,
        input logic bad);
        i_host.send(o, k, b, x, bad);
        n = 99;
        // Look just after the take edge first, then once per cycle
        for (int i = 1; i <= 8 && n == 99; i++) begin
            if (i > 1) @(posedge ref_clk);
            #1;
            if (reply_valid === 1'b1) n = i;
        end
    endtask
    task automatic refuse(input logic [7:0] o, k, b, input logic [31:0] x,
        input logic bad, input logic [7:0] st);
        cmd(o, k, b, x, bad);
        chk("refusal delay", 1, n);
        chk("refusal status", st, reply.status);
        chk("refusal rule", want(o, k, b, x, bad), reply.status);
        chk("refusal opcode", o, reply.opcode);
    endtask
    // One-cycle event on a slot, then settle
    task automatic pulse(input int s);
        @(posedge ref_clk);
        irq_event <= 12'h001 << s;
        @(posedge ref_clk);
        irq_event <= 12'h000;
        idle(4);
    endtask
    // Value read result in the given mode
    task automatic rd(input logic dm, input logic [31:0] x);
        @(posedge ref_clk);
        direct_mode <= dm;
        read_result <= x;
        read_result_valid <= 1'b1;
        @(posedge ref_clk);
        read_result_valid <= 1'b0;
        idle(2);
    endtask
    task automatic wrap_up();
        $display("checks %0d errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // Cut a hang short
    initial begin
        #100000;
        n_errors++;
        wrap_up();
    end
    initial begin
        reset = 1'b1;
        direct_mode = 1'b1;
        read_result_valid = 1'b0;
        read_result = '0;
        irq_event = '0;
        prog_context = '0;
        repeat (10) @(posedge ref_clk);
        reset <= 1'b0;
        idle(1);
        // Both directions at the limits, then random speeds
        for (int k = 0; k < 12; k++) begin
            v = $random(seed) % 2048;
            if (k < 2) v = 32'h000007ff;
            else if (k < 4) v = 32'hfffff801;
            op = k[0] ? 8'h02 : 8'h01;
            cmd(op, 8'h00, 8'h00, v, 1'b0);
            chk("rotate delay", 4, n);
            chk("rotate status", 8'h64, reply.status);
            chk("rot status", want(op, 0, 0, v, 0), reply.status);
            chk("rotate opcode", op, reply.opcode);
            chk("velocity mode", 1, velocity_mode);
            chk("direction", op == 8'h02, motor_dir_ccw);
            chk("speed", v, axis_param_value);
        end
        // Refused: speed past limit, stray fields, bad sum or code
        refuse(8'h01, 8'h00, 8'h00, 32'h00000800, 1'b0, 8'h04);
        refuse(8'h02, 8'h00, 8'h00, 32'hfffff800, 1'b0, 8'h04);
        refuse(8'h01, 8'h01, 8'h00, 32'h00000010, 1'b0, 8'h04);
        refuse(8'h02, 8'h00, 8'h01, 32'h00000010, 1'b0, 8'h04);
        refuse(8'h01, 8'h00, 8'h00, 32'h00000010, 1'b1, 8'h01);
        refuse(8'h77, 8'h00, 8'h00, 32'h00000010, 1'b0, 8'h02);
        chk("speed kept", v, axis_param_value);
        // Slot 0 armed but held off: global off, then source off
        c = calls;
        cmd(8'h25, 8'h00, 8'h00, 32'h00000100, 1'b0);
        cmd(8'h19, 8'h00, 8'h00, 32'h0, 1'b0);
        pulse(0);
        chk("global off", c, calls);
        cmd(8'h1a, 8'h00, 8'h00, 32'h0, 1'b0);
        cmd(8'h19, 8'hff, 8'h00, 32'h0, 1'b0);
        pulse(0);
        chk("source off", c, calls);
        // Each other source: own vector, call, context round trip
        for (int s = 1; s < 12; s++) begin
            @(posedge ref_clk);
            prog_context <= context_s'({$random(seed), $random(seed),
                24'($random(seed))});
            c = calls;
            cmd(8'h25, nums[s], 8'h00, 32'h100 + s, 1'b0);
            cmd(8'h19, nums[s], 8'h00, 32'h0, 1'b0);
            pulse(s);
            chk("dispatch", c + 1, calls);
            chk("vector", 32'h100 + s, call_addr);
            chk("busy", 1, in_handler);
            c = resumes;
            cmd(8'h26, 8'h00, 8'h00, 32'h0, 1'b0);
            idle(2);
            chk("resume", c + 1, resumes);
            chk("context", prog_context, restore_context);
        end
        // A second source waits until the handler returns
        c = calls;
        pulse(5);
        pulse(4);
        chk("no nesting", c + 1, calls);
        cmd(8'h26, 8'h00, 8'h00, 32'h0, 1'b0);
        idle(4);
        chk("pending call", c + 2, calls);
        chk("pending vector", 16'h0104, call_addr);
        cmd(8'h26, 8'h00, 8'h00, 32'h0, 1'b0);
        // Bank 3 writes reach source settings, other banks do not
        cmd(8'h09, 8'h01, 8'h03, 32'd1000, 1'b0);
        chk("cfg write", 1, irq_cfg_write);
        chk("cfg number", 8'h01, irq_cfg_number);
        chk("cfg value", 32'd1000, irq_cfg_value);
        cmd(8'h09, 8'h01, 8'h00, 32'd5, 1'b0);
        chk("cfg other bank", 0, irq_cfg_write);
        // Reads load the accumulator only for the stored program
        v = $random(seed);
        rd(1'b0, v);
        chk("program read", v, accu_out);
        rd(1'b1, ~v);
        chk("direct read", v, accu_out);
        // Stored-program rotate moves the motor but sends no reply
        @(posedge ref_clk);
        direct_mode <= 1'b0;
        cmd(8'h02, 8'h00, 8'h00, 32'h00000123, 1'b0);
        chk("program rotate silent", 99, n);
        chk("program rotate speed", 32'h123, axis_param_value);
        chk("program rotate dir", 1, motor_dir_ccw);
        wrap_up();
    end
endmodule // tb
`default_nettype wire
